// >>> hdl/mbs_defines.svh
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH
`define MBS_START_SHORT 8'h10
`define MBS_START_LONG 8'h68
`define MBS_STOP 8'h16
`define MBS_ACK 8'hE5
`define MBS_C_NKE 8'h40
`define MBS_C_UD 8'h53
`define MBS_C_REQ 8'h5B
`define MBS_C_RSP 8'h08
`define MBS_FCB_BIT 5
`define MBS_FCV_BIT 4
`define MBS_PRM_BIT 6
`define MBS_FN_MASK 8'hDF
`define MBS_REQ_MASK 8'hCF
`define MBS_CI_SEND 8'h51
`define MBS_CI_SEL 8'h52
`define MBS_CI_RSP 8'h72
`define MBS_CI_MODE_BIT 2
`define MBS_ADDR_MAX 8'hFA
`define MBS_ADDR_SEC 8'hFD
`define MBS_ADDR_P2P 8'hFE
`define MBS_ADDR_BC 8'hFF
`define MBS_L_OVH 8'h03
`define MBS_HDR_LEN 8'h0C
`define MBS_REC_MAX 8'hEA
`define MBS_MEDIUM 8'h02
`define MBS_MDH_LAST 8'h0F
`define MBS_MDH_MORE 8'h1F
`define MBS_BAUD_HZ 2400
`define MBS_CLK_HZ 200000000
`define MBS_BIT_CYC (`MBS_CLK_HZ / `MBS_BAUD_HZ)
`define MBS_FRAME_BITS 4'hB
`endif

// >>> hdl/mbs_pkg.sv
package mbs_pkg;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0000,
      RX_LEN1 = 4'b0001,
      RX_LEN2 = 4'b0011,
      RX_ST2 = 4'b0010,
      RX_C = 4'b0110,
      RX_A = 4'b0111,
      RX_CI = 4'b0101,
      RX_DATA = 4'b0100,
      RX_SUM = 4'b1100,
      RX_STOP = 4'b1101
   } mbs_rx_t;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_ACK = 2'b01,
      TX_RSP = 2'b11
   } mbs_tx_t;
endpackage

// >>> hdl/mbs_fifo.sv
module mbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = cnt_r != (AW+1)'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rp_r];
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         if (pop)
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clock)
   begin
      if (push)
         mem[wp_r] <= in_data;
   end
endmodule

// >>> hdl/mbs_slave.sv
`include "mbs_defines.svh"
// What this block does
// - Every frame field is exactly one eight-bit byte.
// - Length field equals user data bytes plus three, sent twice in long frames.
// - Control bit 7 zero, bit 6 set from master, replies clear bits 6..4.
// - With frame-count-valid clear the frame-count bit is ignored.
// - Toggled valid frame-count on data request advances to next telegram, else repeat.
// - Initialization telegram clears the stored frame-count state.
// - One frame-count state serves primary, secondary and point-to-point addressing.
// - Function codes: 40h init, 53h/73h send data, 4Bh/5Bh/6Bh/7Bh data request.
// - Data replies use control code 08h.
// - Address 0 at manufacture; 1 to 250 are primary addresses.
// - Address 253 selects secondary addressing; 251 and 252 do nothing.
// - Point-to-point address 254 gets a reply carrying own primary address.
// - Broadcast address 255 is accepted but never answered.
// - Byte-order mode bit of control-information clear; multibyte values LSB first.
// - Master uses 51h send, 52h select; meter answers with 72h.
// - Reply user data is 12-byte header, records, then one-byte trailer.
// - Header: 4-byte serial, 2-byte maker, version, medium, access, status, signature.
// - Medium byte is 02h and signature bytes are both zero.
// - Access number increments on every successful access.
// - Status bits: busy, internal, power low, permanent, temporary, installation.
// - Total data record length never exceeds 234 bytes.
// - Record: info byte, extensions, value byte, extensions, then data.
// - Bytes framed as start, eight data LSB first, even parity, stop; idle mark.
// - Short frames start 10h, long 68h twice, both end with 16h.
// - Receipt is acknowledged by the single character E5h.
// - Checksum is modulo-256 sum from control through last user data.
module mbs_slave #(
   parameter int BIT_CYC = `MBS_BIT_CYC,
   parameter int REC_DEPTH = 16,
   parameter int FIFO_DEPTH = 16
) (
   // System
   input wire logic clock,
   input wire logic rst,
   // Serial link
   input wire logic rxd,
   output logic txd,
   // Meter identity and status
   input wire logic [7:0] primary_addr,
   input wire logic [31:0] serial_bcd,
   input wire logic [15:0] maker_code,
   input wire logic [7:0] version,
   input wire logic [5:0] status_flags,
   // Data records for replies
   input wire logic rec_valid,
   output logic rec_ready,
   input wire logic [7:0] rec_data,
   input wire logic rec_last,
   input wire logic rec_more,
   // Received user data, next_tel and frame_err pulses, access number
   output logic ud_valid,
   output logic [7:0] ud_data,
   output logic ud_last,
   output logic next_tel,
   output logic frame_err,
   output logic [7:0] access_no
);
   // Bit-rate receiver, samples mid bit
   localparam int HALF = BIT_CYC / 2;
   localparam int CW = $clog2(BIT_CYC + 1);
   logic [CW-1:0] rcnt_r;
   logic [3:0] rbit_r;
   logic [9:0] rsh_r;
   logic rbusy_r;
   logic rb_stb;
   wire rtick = rcnt_r == CW'(BIT_CYC - 1);
   wire [7:0] rbyte = rsh_r[8:1];
   wire rok = (^rsh_r[9:1] == 1'b0) && rxd && !rsh_r[0];
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rcnt_r <= '0;
         rbit_r <= '0;
         rsh_r <= '0;
         rbusy_r <= 1'b0;
         rb_stb <= 1'b0;
      end
      else
      begin
         rb_stb <= 1'b0;
         if (!rbusy_r)
         begin
            if (!rxd)
            begin
               rbusy_r <= 1'b1;
               rcnt_r <= CW'(BIT_CYC - HALF);
               rbit_r <= '0;
            end
         end
         else if (rtick)
         begin
            rcnt_r <= '0;
            if (rbit_r == `MBS_FRAME_BITS - 4'h1)
            begin
               rbusy_r <= 1'b0;
               rb_stb <= rok;
            end
            else
            begin
               rsh_r <= {rxd, rsh_r[9:1]};
               rbit_r <= rbit_r + 4'h1;
            end
         end
         else
            rcnt_r <= rcnt_r + CW'(1);
      end
   end

   // Frame parser
   mbs_pkg::mbs_rx_t st_r;
   logic long_r;
   logic [7:0] len_r;
   logic [7:0] left_r;
   logic [7:0] c_r;
   logic [7:0] a_r;
   logic [7:0] ci_r;
   logic [7:0] sum_r;
   logic fcb_r;
   logic fcb_known_r;
   logic tel_ok;
   wire [7:0] fn = c_r & `MBS_FN_MASK;
   wire is_nke = !long_r && c_r == `MBS_C_NKE;
   // Request decoded with the frame-count-valid bit free, so a request without it still answers
   wire is_req = !long_r && (c_r & `MBS_REQ_MASK) == (`MBS_C_REQ & `MBS_REQ_MASK);
   wire is_ud = long_r && fn == `MBS_C_UD;
   wire ci_ok = ci_r == `MBS_CI_SEND || ci_r == `MBS_CI_SEL;
   wire a_prim = a_r == primary_addr && primary_addr <= `MBS_ADDR_MAX;
   wire a_match = a_prim || a_r == `MBS_ADDR_SEC || a_r == `MBS_ADDR_P2P
                  || a_r == `MBS_ADDR_BC;
   wire a_bc = a_r == `MBS_ADDR_BC;
   wire c_ok = !c_r[7] && c_r[`MBS_PRM_BIT];
   wire fn_ok = is_nke || is_req || (is_ud && ci_ok);
   wire fcv = c_r[`MBS_FCV_BIT];
   wire fcb = c_r[`MBS_FCB_BIT];
   wire advance = is_req && fcv && fcb_known_r && fcb != fcb_r;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st_r <= mbs_pkg::RX_IDLE;
         long_r <= 1'b0;
         len_r <= '0;
         left_r <= '0;
         c_r <= '0;
         a_r <= '0;
         ci_r <= '0;
         sum_r <= '0;
         tel_ok <= 1'b0;
         frame_err <= 1'b0;
         ud_valid <= 1'b0;
         ud_data <= '0;
         ud_last <= 1'b0;
      end
      else
      begin
         tel_ok <= 1'b0;
         frame_err <= 1'b0;
         ud_valid <= 1'b0;
         ud_last <= 1'b0;
         if (rb_stb)
         begin
            case (st_r)
               mbs_pkg::RX_IDLE:
               begin
                  sum_r <= '0;
                  if (rbyte == `MBS_START_SHORT)
                  begin
                     long_r <= 1'b0;
                     st_r <= mbs_pkg::RX_C;
                  end
                  else if (rbyte == `MBS_START_LONG)
                  begin
                     long_r <= 1'b1;
                     st_r <= mbs_pkg::RX_LEN1;
                  end
               end
               mbs_pkg::RX_LEN1:
               begin
                  len_r <= rbyte;
                  st_r <= (rbyte >= `MBS_L_OVH) ? mbs_pkg::RX_LEN2 : mbs_pkg::RX_IDLE;
               end
               mbs_pkg::RX_LEN2:
                  st_r <= (rbyte == len_r) ? mbs_pkg::RX_ST2 : mbs_pkg::RX_IDLE;
               mbs_pkg::RX_ST2:
                  st_r <= (rbyte == `MBS_START_LONG) ? mbs_pkg::RX_C : mbs_pkg::RX_IDLE;
               mbs_pkg::RX_C:
               begin
                  c_r <= rbyte;
                  sum_r <= rbyte;
                  st_r <= mbs_pkg::RX_A;
               end
               mbs_pkg::RX_A:
               begin
                  a_r <= rbyte;
                  sum_r <= sum_r + rbyte;
                  left_r <= len_r - `MBS_L_OVH;
                  st_r <= long_r ? mbs_pkg::RX_CI : mbs_pkg::RX_SUM;
               end
               mbs_pkg::RX_CI:
               begin
                  ci_r <= rbyte;
                  sum_r <= sum_r + rbyte;
                  st_r <= (left_r == '0) ? mbs_pkg::RX_SUM : mbs_pkg::RX_DATA;
               end
               mbs_pkg::RX_DATA:
               begin
                  sum_r <= sum_r + rbyte;
                  left_r <= left_r - 8'h01;
                  ud_valid <= 1'b1;
                  ud_data <= rbyte;
                  ud_last <= left_r == 8'h01;
                  if (left_r == 8'h01)
                     st_r <= mbs_pkg::RX_SUM;
               end
               mbs_pkg::RX_SUM:
               begin
                  frame_err <= rbyte != sum_r;
                  st_r <= (rbyte == sum_r) ? mbs_pkg::RX_STOP : mbs_pkg::RX_IDLE;
               end
               mbs_pkg::RX_STOP:
               begin
                  tel_ok <= rbyte == `MBS_STOP && a_match && c_ok && fn_ok;
                  frame_err <= rbyte != `MBS_STOP;
                  st_r <= mbs_pkg::RX_IDLE;
               end
               default:
                  st_r <= mbs_pkg::RX_IDLE;
            endcase
         end
      end
   end

   // Single frame-count state for every addressing mode
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fcb_r <= 1'b0;
         fcb_known_r <= 1'b0;
         access_no <= '0;
         next_tel <= 1'b0;
      end
      else
      begin
         next_tel <= 1'b0;
         if (tel_ok)
         begin
            access_no <= access_no + 8'h01;
            if (is_nke)
            begin
               fcb_r <= 1'b0;
               fcb_known_r <= 1'b1;
            end
            else if (is_req && fcv)
            begin
               fcb_r <= fcb;
               fcb_known_r <= 1'b1;
               next_tel <= advance;
            end
         end
      end
   end

   // Reply record buffer
   logic f_valid;
   logic f_ready;
   logic [9:0] f_data;
   logic f_in_ready;
   mbs_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(rec_valid),
      .in_ready(f_in_ready),
      .in_data({rec_more, rec_last, rec_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );
   // Fill count kept here so the reply length is known before the records leave
   localparam int QW = $clog2(FIFO_DEPTH) + 1;
   logic [QW-1:0] qcnt_r;
   wire q_push = rec_valid && f_in_ready;
   wire q_pop = f_valid && f_ready;
   wire [QW-1:0] qcnt_nxt = qcnt_r + QW'(q_push) - QW'(q_pop);
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         qcnt_r <= '0;
         rec_ready <= 1'b1;
      end
      else
      begin
         qcnt_r <= qcnt_nxt;
         rec_ready <= qcnt_nxt != QW'(FIFO_DEPTH);
      end
   end

   // Transmitter
   mbs_pkg::mbs_tx_t tst_r;
   logic [CW-1:0] tcnt_r;
   logic [3:0] tbit_r;
   logic [10:0] tsh_r;
   logic tbusy_r;
   logic [7:0] idx_r;
   logic [7:0] tsum_r;
   logic [7:0] rlen_r;
   logic [7:0] nrec_r;
   logic rec_done_r;
   logic more_r;
   logic [7:0] reply_a_r;
   logic [7:0] tx_byte;
   wire tload = !tbusy_r;
   // Reply byte index: 0 start,1-2 L,3 start,4 C,5 A,6 CI,7-18 header,records,MDH,sum,stop
   localparam logic [7:0] HDR0 = 8'h07;
   wire [7:0] hidx = idx_r - HDR0;
   wire in_rec = idx_r >= HDR0 + `MBS_HDR_LEN && !rec_done_r;
   logic [7:0] hdr_byte;
   always_comb
   begin
      case (hidx[3:0])
         4'h0: hdr_byte = serial_bcd[7:0];
         4'h1: hdr_byte = serial_bcd[15:8];
         4'h2: hdr_byte = serial_bcd[23:16];
         4'h3: hdr_byte = serial_bcd[31:24];
         4'h4: hdr_byte = maker_code[7:0];
         4'h5: hdr_byte = maker_code[15:8];
         4'h6: hdr_byte = version;
         4'h7: hdr_byte = `MBS_MEDIUM;
         4'h8: hdr_byte = access_no;
         4'h9: hdr_byte = {2'b00, status_flags};
         default: hdr_byte = 8'h00;
      endcase
   end
   wire [7:0] tail = idx_r - HDR0 - `MBS_HDR_LEN - rlen_r;
   always_comb
   begin
      tx_byte = 8'h00;
      if (tst_r == mbs_pkg::TX_ACK)
         tx_byte = `MBS_ACK;
      else if (idx_r == 8'h00 || idx_r == 8'h03)
         tx_byte = `MBS_START_LONG;
      else if (idx_r == 8'h01 || idx_r == 8'h02)
         // Fixed from the buffer fill at request time: load one telegram's records only
         tx_byte = nrec_r + `MBS_HDR_LEN + 8'h01 + `MBS_L_OVH;
      else if (idx_r == 8'h04)
         tx_byte = `MBS_C_RSP;
      else if (idx_r == 8'h05)
         tx_byte = reply_a_r;
      else if (idx_r == 8'h06)
         tx_byte = `MBS_CI_RSP;
      else if (idx_r < HDR0 + `MBS_HDR_LEN)
         tx_byte = hdr_byte;
      else if (in_rec)
         tx_byte = f_data[7:0];
      else if (tail == 8'h00)
         tx_byte = more_r ? `MBS_MDH_MORE : `MBS_MDH_LAST;
      else if (tail == 8'h01)
         tx_byte = tsum_r;
      else
         tx_byte = `MBS_STOP;
   end
   wire rec_stall = in_rec && !f_valid;
   wire tx_go = tload && tst_r != mbs_pkg::TX_IDLE && !rec_stall;
   assign f_ready = tx_go && in_rec;
   wire [7:0] last_idx = HDR0 + `MBS_HDR_LEN + rlen_r + 8'h02;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         tst_r <= mbs_pkg::TX_IDLE;
         tcnt_r <= '0;
         tbit_r <= '0;
         tsh_r <= '1;
         tbusy_r <= 1'b0;
         idx_r <= '0;
         tsum_r <= '0;
         rlen_r <= '0;
         nrec_r <= '0;
         rec_done_r <= 1'b0;
         more_r <= 1'b0;
         reply_a_r <= '0;
         txd <= 1'b1;
      end
      else
      begin
         txd <= tbusy_r ? tsh_r[0] : 1'b1;
         if (tbusy_r)
         begin
            if (tcnt_r == CW'(BIT_CYC - 1))
            begin
               tcnt_r <= '0;
               tsh_r <= {1'b1, tsh_r[10:1]};
               tbit_r <= tbit_r + 4'h1;
               if (tbit_r == `MBS_FRAME_BITS - 4'h1)
                  tbusy_r <= 1'b0;
            end
            else
               tcnt_r <= tcnt_r + CW'(1);
         end
         if (tst_r == mbs_pkg::TX_IDLE && tel_ok && !a_bc)
         begin
            tst_r <= is_req ? mbs_pkg::TX_RSP : mbs_pkg::TX_ACK;
            idx_r <= '0;
            tsum_r <= '0;
            rlen_r <= '0;
            nrec_r <= (8'(qcnt_r) > `MBS_REC_MAX) ? `MBS_REC_MAX : 8'(qcnt_r);
            rec_done_r <= qcnt_r == '0;
            more_r <= 1'b0;
            reply_a_r <= primary_addr;
         end
         else if (tx_go)
         begin
            tbusy_r <= 1'b1;
            tcnt_r <= '0;
            tbit_r <= '0;
            tsh_r <= {1'b1, ^tx_byte, tx_byte, 1'b0};
            idx_r <= idx_r + 8'h01;
            if (idx_r >= 8'h04)
               tsum_r <= tsum_r + tx_byte;
            if (in_rec)
            begin
               rlen_r <= rlen_r + 8'h01;
               rec_done_r <= f_data[8] || rlen_r + 8'h01 == nrec_r;
               more_r <= f_data[9];
            end
            if (tst_r == mbs_pkg::TX_ACK || idx_r == last_idx)
               tst_r <= mbs_pkg::TX_IDLE;
         end
      end
   end
   AST_NKE_CLR: assert property (@(posedge clock) disable iff (rst)
      tel_ok && is_nke |=> !fcb_r) else $error("init did not clear frame count");
   AST_ACC_INC: assert property (@(posedge clock) disable iff (rst)
      tel_ok |=> access_no == $past(access_no) + 8'h01) else $error("access not counted");
   AST_NO_BC: assert property (@(posedge clock) disable iff (rst)
      tel_ok && a_bc && tst_r == mbs_pkg::TX_IDLE |=> tst_r == mbs_pkg::TX_IDLE)
      else $error("broadcast answered");
   AST_ADV: assert property (@(posedge clock) disable iff (rst)
      tel_ok && is_req && !fcv |=> !next_tel) else $error("ignored frame count used");
   AST_TOGGLE: assert property (@(posedge clock) disable iff (rst)
      tel_ok && advance |=> next_tel && fcb_r == !$past(fcb_r)) else $error("toggle missed");
   AST_IDLE_MARK: assert property (@(posedge clock) disable iff (rst)
      !tbusy_r && !$past(tbusy_r) |-> txd) else $error("line not idle at mark");
   AST_REC_MAX: assert property (@(posedge clock) disable iff (rst)
      rlen_r <= `MBS_REC_MAX) else $error("record length over limit");
   AST_DROP: assert property (@(posedge clock) disable iff (rst)
      tel_ok |-> a_match) else $error("foreign telegram accepted");
endmodule

// >>> test/mbs_master_model.sv
module mbs_master_model #(
   parameter int BIT_CYC = 16
) (
   // Link
   input wire logic clock,
   output logic line_out,
   input wire logic line_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial line_out = 1'b1;
   task automatic send(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ^b, b, 1'b0};
      // Returns at mid stop bit, as the meter may answer right after it; the lead-in completes the stop
      repeat (BIT_CYC / 2) @(posedge clock);
      for (int i = 0; i < 11; i++)
      begin
         line_out <= f[i];
         repeat (i < 10 ? BIT_CYC : BIT_CYC / 2) @(posedge clock);
      end
   endtask
   // Samples each bit at its middle; returns with ok low on a bad frame or silence
   task automatic recv(output logic [7:0] b, output logic ok);
      logic [10:0] f;
      int t;
      t = 0;
      ok = 1'b0;
      b = 8'h00;
      while (line_in !== 1'b0 && t < 4000)
      begin
         @(negedge clock);
         t++;
      end
      if (t < 4000)
      begin
         repeat (BIT_CYC / 2) @(negedge clock);
         for (int i = 0; i < 11; i++)
         begin
            f[i] = line_in;
            if (i < 10)
               repeat (BIT_CYC) @(negedge clock);
         end
         b = f[8:1];
         ok = (f[0] === 1'b0) && (^f[9:1] === 1'b0) && (f[10] === 1'b1);
      end
   endtask
   task automatic short_frame(input logic [7:0] c, input logic [7:0] a, input logic [7:0] bad);
      send(8'h10);
      send(c);
      send(a);
      send(c + a + bad);
      send(8'h16);
   endtask
   task automatic long_frame(input logic [7:0] c, input logic [7:0] a, input logic [7:0] ci,
                             input logic [7:0] d0, input logic [7:0] d1);
      send(8'h68);
      send(8'h05);
      send(8'h05);
      send(8'h68);
      send(c);
      send(a);
      send(ci);
      send(d0);
      send(d1);
      send(c + a + ci + d0 + d1);
      send(8'h16);
   endtask
endmodule

// >>> test/meter_bus_slave_telegram_fields_tb.sv
module meter_bus_slave_telegram_fields_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BC = 16;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic rxd;
   logic txd;
   logic [7:0] primary_addr = 8'h05;
   logic [31:0] serial_bcd = 32'h1234_5678;
   // Arbitrary maker value
   logic [15:0] maker_code = 16'h1A2B;
   logic [7:0] version = 8'h03;
   logic [5:0] status_flags = 6'h25;
   logic rec_valid = 1'b0;
   logic rec_ready;
   logic [7:0] rec_data = 8'h00;
   logic rec_last = 1'b0;
   logic rec_more = 1'b0;
   logic ud_valid;
   logic [7:0] ud_data;
   logic ud_last;
   logic next_tel;
   logic frame_err;
   logic [7:0] access_no;
   logic [7:0] ud_buf[0:15];
   logic ud_lst[0:15];
   logic [7:0] rx[0:63];
   logic [7:0] e[0:63];
   logic [7:0] b;
   int n_next = 0;
   int n_err = 0;
   int n_ud = 0;
   int acc = 0;
   int fails = 0;
   int checked = 0;
   always #2.5 clock = ~clock;
   mbs_slave #(.BIT_CYC(BC)) DUT (.clock(clock), .rst(rst), .rxd(rxd), .txd(txd),
      .primary_addr(primary_addr), .serial_bcd(serial_bcd), .maker_code(maker_code),
      .version(version), .status_flags(status_flags), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rec_data(rec_data), .rec_last(rec_last), .rec_more(rec_more),
      .ud_valid(ud_valid), .ud_data(ud_data), .ud_last(ud_last), .next_tel(next_tel),
      .frame_err(frame_err), .access_no(access_no));
   mbs_master_model #(.BIT_CYC(BC)) master (.clock(clock), .line_out(rxd), .line_in(txd));
   // Pulse counters, sampled away from the launching edge
   always @(negedge clock)
   begin
      if (next_tel === 1'b1)
         n_next++;
      if (frame_err === 1'b1)
         n_err++;
      if (ud_valid === 1'b1 && n_ud < 16)
      begin
         ud_buf[n_ud] = ud_data;
         ud_lst[n_ud] = ud_last;
         n_ud++;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic get(output logic [7:0] v);
      logic ok;
      master.recv(v, ok);
      check(ok, 1'b1);
      if (ok !== 1'b1)
         summarize;
   endtask
   task automatic quiet;
      logic low;
      low = 1'b0;
      repeat (700) @(negedge clock) if (txd === 1'b0) low = 1'b1;
      check(low, 1'b0);
   endtask
   task automatic push(input int n, input logic more);
      int t;
      @(posedge clock);
      for (int i = 0; i < n; i++)
      begin
         rec_valid <= 1'b1;
         rec_data <= 8'h30 + 8'(i);
         rec_last <= (i == n - 1);
         rec_more <= more;
         #1;
         t = 0;
         while (rec_ready !== 1'b1 && t < 100)
         begin
            @(posedge clock);
            #1;
            t++;
         end
         check(t < 100, 1'b1);
         if (t >= 100)
            summarize;
         @(posedge clock);
      end
      rec_valid <= 1'b0;
   endtask
   task automatic rsp(input int r, input logic [7:0] mdh, input logic [7:0] addr);
      logic [7:0] s;
      e[0] = 8'h68;
      e[1] = 8'(r + 16);
      e[2] = 8'(r + 16);
      e[3] = 8'h68;
      e[4] = 8'h08;
      e[5] = addr;
      e[6] = 8'h72;
      {e[10], e[9], e[8], e[7]} = serial_bcd;
      {e[12], e[11]} = maker_code;
      e[13] = version;
      e[14] = 8'h02;
      acc++;
      e[15] = 8'(acc);
      e[16] = {2'b00, status_flags};
      e[17] = 8'h00;
      e[18] = 8'h00;
      for (int i = 0; i < r; i++)
         e[19 + i] = 8'h30 + 8'(i);
      e[19 + r] = mdh;
      e[21 + r] = 8'h16;
      for (int i = 0; i < 22 + r; i++)
         get(rx[i]);
      s = 8'h00;
      for (int i = 4; i < 20 + r; i++)
         s = s + rx[i];
      for (int i = 0; i < 22 + r; i++)
         if (i != 20 + r) check(rx[i], e[i]);
      check(rx[20 + r], s);
      repeat (BC) @(posedge clock);
   endtask
   task automatic t_init;
      master.short_frame(8'h40, 8'h05, 8'h00);
      get(b);
      check(b, 8'hE5);
      repeat (2 * BC) @(posedge clock);
      acc++;
      check(access_no, 8'(acc));
      $display("test init done");
   endtask
   task automatic t_req;
      int nn;
      push(16, 1'b1);
      #1;
      check(rec_ready, 1'b0);
      nn = n_next;
      master.short_frame(8'h7B, 8'h05, 8'h00);
      rsp(16, 8'h1F, 8'h05);
      check(n_next, nn + 1);
      check(rec_ready, 1'b1);
      check(access_no, 8'(acc));
      push(2, 1'b0);
      master.short_frame(8'h7B, 8'h05, 8'h00);
      rsp(2, 8'h0F, 8'h05);
      check(n_next, nn + 1);
      push(2, 1'b0);
      master.short_frame(8'h5B, 8'hFE, 8'h00);
      rsp(2, 8'h0F, 8'h05);
      check(n_next, nn + 2);
      push(2, 1'b0);
      master.short_frame(8'h6B, 8'h05, 8'h00);
      rsp(2, 8'h0F, 8'h05);
      check(n_next, nn + 2);
      push(2, 1'b0);
      master.short_frame(8'h7B, 8'h05, 8'h00);
      rsp(2, 8'h0F, 8'h05);
      check(n_next, nn + 3);
      $display("test request done");
   endtask
   task automatic t_quiet;
      logic [7:0] al[4];
      al = '{8'hFF, 8'hFB, 8'hFC, 8'h22};
      for (int i = 0; i < 4; i++)
      begin
         master.short_frame(8'h40, al[i], 8'h00);
         quiet;
      end
      $display("test silent addresses done");
   endtask
   task automatic t_ud;
      int nu;
      nu = n_ud;
      master.long_frame(8'h53, 8'h05, 8'h51, 8'hAA, 8'h55);
      get(b);
      check(b, 8'hE5);
      check(n_ud, nu + 2);
      check(ud_buf[nu], 8'hAA);
      check(ud_buf[nu + 1], 8'h55);
      check(ud_lst[nu + 1], 1'b1);
      repeat (BC) @(posedge clock);
      master.long_frame(8'h73, 8'h05, 8'h52, 8'h01, 8'h02);
      get(b);
      check(b, 8'hE5);
      repeat (BC) @(posedge clock);
      $display("test user data done");
   endtask
   task automatic t_bad;
      int ne;
      ne = n_err;
      master.short_frame(8'h40, 8'h05, 8'h01);
      quiet;
      check(n_err, ne + 1);
      $display("test bad checksum done");
   endtask
   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      t_init;
      t_req;
      t_quiet;
      t_ud;
      t_bad;
      summarize;
   end
endmodule
